// file: hw/tpom_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module tpom_monitor
    import tpom_pkg::*;
#(
    parameter int JUST_CNT_W = 13,
    parameter int ERR_CNT_W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Received overhead, valid on frame_i
    input wire logic frame_i,
    input wire logic [15:0] pointer_word_i,
    input wire logic [7:0] c2_i,
    input wire logic [7:0] g1_i,
    input wire logic [3:0] b3_errors_i,
    // Configuration levels
    input wire logic tu3_mode_i,
    input wire logic slave_slot_i,
    input wire logic label_five_frame_select_i,
    input wire logic remote_defect_ten_frame_select_i,
    // Indirect register access
    input wire logic ind_rd_i,
    input wire logic ind_wr_i,
    input wire logic [3:0] ind_addr_i,
    input wire logic [15:0] ind_wdata_i,
    input wire logic counters_update_i,
    output logic [15:0] ind_rdata_o,
    output logic ind_rd_valid_o,
    // Label conditions
    output logic label_mismatch_o,
    output logic unequipped_o,
    output logic payload_defect_o
);

    // Holding registers are sixteen bits wide, so wider counters cannot fit
    if (JUST_CNT_W < 13 || JUST_CNT_W > 16 ||
        ERR_CNT_W < 16 || ERR_CNT_W > 16) begin : g_bad_width
        $error("tpom_monitor: counter widths unsupported");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pointer word decode

    logic [3:0] ndf_code;
    logic [1:0] ss_bits;
    logic [9:0] rx_ofs;
    logic [9:0] pointer_offset_value_reg;
    logic [1:0] size_bits_value_reg;
    logic [2:0] since_just_reg;
    logic [9:0] new_ofs_reg;
    logic [1:0] new_cnt_reg;
    logic [9:0] max_ofs;
    logic [9:0] ofs_diff;
    wire ndf_is_enabled;
    wire ndf_is_normal;
    wire is_ais;
    wire in_range;
    wire inc_req;
    wire dec_req;
    wire just_ok;
    wire concat_ev;
    wire ndf_ev;
    wire illj_ev;
    wire illegal_offset_flag_ev;
    wire invalid_new_data_flag_ev;
    wire new_ofs_seen;
    wire disc_ev;
    wire inc_do;
    wire dec_do;

    assign ndf_code = pointer_word_i[15:12];
    assign ss_bits = pointer_word_i[11:10];
    assign rx_ofs = pointer_word_i[9:0];
    assign max_ofs = tu3_mode_i ? MAX_OFS_TU3 : MAX_OFS_STS;
    assign ofs_diff = rx_ofs ^ pointer_offset_value_reg;
    // Single bit errors in the flag are tolerated
    assign ndf_is_enabled = $countones(ndf_code ^ NDF_ENABLED) <= 1;
    assign ndf_is_normal = $countones(ndf_code ^ NDF_NORMAL) <= 1;
    assign is_ais = pointer_word_i == AIS_WORD;
    assign in_range = rx_ofs <= max_ofs;
    assign inc_req = ndf_is_normal &&
                     $countones(ofs_diff & I_BIT_MASK) >= 3 &&
                     $countones(ofs_diff & D_BIT_MASK) < 3;
    assign dec_req = ndf_is_normal &&
                     $countones(ofs_diff & D_BIT_MASK) >= 3 &&
                     $countones(ofs_diff & I_BIT_MASK) < 3;
    // The last adjustment must lie more than three frames back: the count
    // reads k-1 on the k-th frame after it, so three means four frames ago
    assign just_ok = since_just_reg >= 3'(JUST_GUARD_FRAMES);
    assign concat_ev = ndf_is_enabled && rx_ofs == OFS_ALL_ONES;
    assign ndf_ev = ndf_is_enabled && !concat_ev && in_range;
    assign illj_ev = (inc_req || dec_req) && !just_ok;
    assign illegal_offset_flag_ev = !is_ais && !inc_req && !dec_req && !in_range;
    assign invalid_new_data_flag_ev = !is_ais && !ndf_is_enabled && !ndf_is_normal;
    assign inc_do = inc_req && just_ok;
    assign dec_do = dec_req && just_ok;
    assign new_ofs_seen = ndf_is_normal && in_range && !inc_req &&
                          !dec_req && rx_ofs != pointer_offset_value_reg;
    assign disc_ev = new_ofs_seen && rx_ofs == new_ofs_reg &&
                     new_cnt_reg == 2'(NEW_PTR_FRAMES - 1);

    ////////////////////////////////////////////////////////////////////////
    // Pointer state

    logic [9:0] ptr_next;
    logic [2:0] since_next;

    always_comb begin
        ptr_next = pointer_offset_value_reg;
        since_next = just_ok ? since_just_reg : since_just_reg + 3'd1;
        if (ndf_ev) begin
            ptr_next = rx_ofs;
            since_next = 3'd0;
        end else if (inc_do) begin
            ptr_next = (pointer_offset_value_reg >= max_ofs) ? 10'd0 :
                       pointer_offset_value_reg + 10'd1;
            since_next = 3'd0;
        end else if (dec_do) begin
            ptr_next = (pointer_offset_value_reg == 10'd0) ? max_ofs :
                       pointer_offset_value_reg - 10'd1;
            since_next = 3'd0;
        end else if (disc_ev) begin
            ptr_next = rx_ofs;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pointer_offset_value_reg <= 10'd0;
            size_bits_value_reg <= 2'd0;
            since_just_reg <= 3'd0;
            new_ofs_reg <= 10'd0;
            new_cnt_reg <= 2'd0;
        end else if (frame_i && !is_ais) begin
            pointer_offset_value_reg <= ptr_next;
            size_bits_value_reg <= ss_bits;
            since_just_reg <= since_next;
            new_ofs_reg <= rx_ofs;
            if (!new_ofs_seen || disc_ev) begin
                new_cnt_reg <= 2'd0;
            end else if (rx_ofs == new_ofs_reg) begin
                new_cnt_reg <= new_cnt_reg + 2'd1;
            end else begin
                new_cnt_reg <= 2'd1;
            end
        end
    end

    // Latest-frame flags; cleared for slave slots where they mean nothing
    logic [5:0] pi_flags_reg;
    logic [15:0] pi_flags_word;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pi_flags_reg <= 6'd0;
        end else if (frame_i) begin
            pi_flags_reg <= slave_slot_i ? 6'd0 :
                {ndf_ev, illegal_offset_flag_ev, invalid_new_data_flag_ev, disc_ev, concat_ev, illj_ev};
        end
    end

    assign pi_flags_word = {9'd0, pi_flags_reg, 1'b0};

    ////////////////////////////////////////////////////////////////////////
    // Signal label and remote defect filters

    logic [7:0] captured_label_reg;
    logic [7:0] accepted_label_reg;
    logic [7:0] label_cand_reg;
    logic [2:0] label_cnt_reg;
    logic [2:0] rdi_cand_reg;
    logic [3:0] rdi_cnt_reg;
    logic [2:0] filtered_remote_defect_code_reg;
    logic [2:0] label_need;
    logic [3:0] rdi_need;
    logic [2:0] rx_erdi;
    logic [2:0] label_cnt_next;
    logic [3:0] rdi_cnt_next;

    assign label_need = label_five_frame_select_i ? 3'(LABEL_FRAMES_HI) :
                        3'(LABEL_FRAMES_LO);
    assign rdi_need = remote_defect_ten_frame_select_i ?
                      4'(RDI_FRAMES_HI) : 4'(RDI_FRAMES_LO);
    // G1 bits 5,6,7 in transmission order sit at [3:1]
    assign rx_erdi = g1_i[3:1];
    assign label_cnt_next = (c2_i != label_cand_reg) ? 3'd1 :
        (label_cnt_reg >= label_need) ? label_need : label_cnt_reg + 3'd1;
    assign rdi_cnt_next = (rx_erdi != rdi_cand_reg) ? 4'd1 :
        (rdi_cnt_reg >= rdi_need) ? rdi_need : rdi_cnt_reg + 4'd1;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            captured_label_reg <= 8'h00;
            accepted_label_reg <= 8'h00;
            label_cand_reg <= 8'h00;
            label_cnt_reg <= 3'd0;
            rdi_cand_reg <= 3'd0;
            rdi_cnt_reg <= 4'd0;
            filtered_remote_defect_code_reg <= 3'd0;
        end else if (frame_i) begin
            captured_label_reg <= c2_i;
            label_cand_reg <= c2_i;
            label_cnt_reg <= label_cnt_next;
            if (label_cnt_next == label_need) begin
                accepted_label_reg <= c2_i;
            end
            rdi_cand_reg <= rx_erdi;
            rdi_cnt_reg <= rdi_cnt_next;
            if (rdi_cnt_next == rdi_need) begin
                filtered_remote_defect_code_reg <= rx_erdi;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Expected label and defect indication

    logic [15:0] expected_label_reg;
    logic [7:0] expected_label;
    logic [4:0] defect_indication_field;
    logic defect_range_enable;
    logic [7:0] pdi_top;
    wire exp_wr;
    wire acc_is_pdi;

    assign exp_wr = ind_wr_i && ind_addr_i == IA_EXPECTED;
    assign expected_label = expected_label_reg[EXP_LABEL_LSB +: 8];
    assign defect_indication_field = expected_label_reg[PDI_LSB +: 5];
    assign defect_range_enable = expected_label_reg[PDI_RANGE_BIT];
    assign pdi_top = PDI_BASE + {3'd0, defect_indication_field};
    assign acc_is_pdi = defect_range_enable ?
        (accepted_label_reg >= PDI_RANGE_LO &&
         accepted_label_reg <= pdi_top) :
        (accepted_label_reg == pdi_top);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            expected_label_reg <= EXPECTED_RST;
            label_mismatch_o <= 1'b0;
            unequipped_o <= 1'b0;
            payload_defect_o <= 1'b0;
        end else begin
            if (exp_wr) begin
                expected_label_reg <= ind_wdata_i & EXPECTED_MASK;
            end
            unequipped_o <= accepted_label_reg == LABEL_UNEQ;
            payload_defect_o <= acc_is_pdi;
            label_mismatch_o <= accepted_label_reg != expected_label &&
                !acc_is_pdi && accepted_label_reg != LABEL_UNEQ;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Performance counters; a snapshot both freezes and restarts them

    logic [15:0] acc_reg [4];
    logic [15:0] hold_reg [4];
    logic [3:0] cnt_incr [4];
    logic [15:0] cnt_mask [4];
    logic [3:0] rei_errors;

    // REI codes above eight carry no errors
    assign rei_errors = (g1_i[7:4] > MAX_BIP_ERRS) ? 4'd0 : g1_i[7:4];
    assign cnt_incr[CNT_PARITY] = frame_i ? b3_errors_i : 4'd0;
    assign cnt_incr[CNT_REMOTE] = frame_i ? rei_errors : 4'd0;
    assign cnt_incr[CNT_NEG] = {3'd0, frame_i && !is_ais && dec_do};
    assign cnt_incr[CNT_POS] = {3'd0, frame_i && !is_ais && inc_do};
    assign cnt_mask[CNT_PARITY] = 16'((32'd1 << ERR_CNT_W) - 1);
    assign cnt_mask[CNT_REMOTE] = 16'((32'd1 << ERR_CNT_W) - 1);
    assign cnt_mask[CNT_NEG] = 16'((32'd1 << JUST_CNT_W) - 1);
    assign cnt_mask[CNT_POS] = 16'((32'd1 << JUST_CNT_W) - 1);

    for (genvar i = 0; i < 4; i++) begin : g_cnt
        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                acc_reg[i] <= 16'h0000;
                hold_reg[i] <= 16'h0000;
            end else if (counters_update_i) begin
                hold_reg[i] <= acc_reg[i];
                acc_reg[i] <= {12'd0, cnt_incr[i]};
            end else begin
                acc_reg[i] <= (acc_reg[i] + {12'd0, cnt_incr[i]}) &
                              cnt_mask[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Indirect read port

    logic [15:0] rd_word;

    always_comb begin
        case (ind_addr_i)
            IA_PTR_VALUE: rd_word = {filtered_remote_defect_code_reg, 1'b0,
                                     size_bits_value_reg,
                                     pointer_offset_value_reg};
            IA_LABELS: rd_word = {captured_label_reg, accepted_label_reg};
            IA_EXPECTED: rd_word = expected_label_reg;
            IA_PI_FLAGS: rd_word = pi_flags_word;
            IA_PARITY_CNT: rd_word = hold_reg[CNT_PARITY];
            IA_REMOTE_CNT: rd_word = hold_reg[CNT_REMOTE];
            IA_NEG_JUST_CNT: rd_word = hold_reg[CNT_NEG];
            IA_POS_JUST_CNT: rd_word = hold_reg[CNT_POS];
            default: rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ind_rdata_o <= 16'h0000;
            ind_rd_valid_o <= 1'b0;
        end else begin
            ind_rd_valid_o <= ind_rd_i;
            if (ind_rd_i) begin
                ind_rdata_o <= rd_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_snapshot;
        counters_update_i;
    endsequence

    sequence s_read_counter;
        ind_rd_i && ind_addr_i == IA_PARITY_CNT;
    endsequence

    chk_captured_label: assert property (
        frame_i |=> captured_label_reg == $past(c2_i))
        else $error("captured label not loaded from C2");

    chk_label_accept: assert property (
        frame_i && label_cnt_next == label_need |=>
        accepted_label_reg == $past(c2_i))
        else $error("label not accepted at persistence count");

    chk_label_hold: assert property (
        frame_i && c2_i != label_cand_reg && label_need > 3'd1 |=>
        $stable(accepted_label_reg))
        else $error("label accepted on first sighting");

    chk_rdi_filter: assert property (
        !frame_i |=> $stable(filtered_remote_defect_code_reg))
        else $error("remote defect code moved between frames");

    chk_pdi_single: assert property (
        !defect_range_enable && accepted_label_reg == pdi_top |=>
        payload_defect_o)
        else $error("exact defect indication missed");

    chk_pdi_range: assert property (
        defect_range_enable && accepted_label_reg >= 8'hE1 &&
        accepted_label_reg <= 8'hE0 + {3'd0, defect_indication_field} |=>
        payload_defect_o)
        else $error("defect range label missed");

    chk_counter_snap: assert property (
        s_snapshot ##1 !counters_update_i ##1 s_read_counter |=>
        ind_rd_valid_o && ind_rdata_o == $past(acc_reg[CNT_PARITY], 3))
        else $error("snapshot not readable from holding register");

    chk_counter_restart: assert property (
        counters_update_i |=> acc_reg[CNT_REMOTE] ==
        {12'd0, $past(cnt_incr[CNT_REMOTE])})
        else $error("counter did not restart after snapshot");

    chk_illjust_flag: assert property (
        frame_i && !slave_slot_i && (inc_req || dec_req) &&
        since_just_reg <= 3'd1 |=> pi_flags_reg[FLAG_ILLJ_BIT - 1])
        else $error("early justification not flagged");

    chk_disc_update: assert property (
        frame_i && !is_ais && disc_ev && !ndf_ev && !inc_do && !dec_do |=>
        pointer_offset_value_reg == $past(rx_ofs))
        else $error("third repeat did not move the pointer");

    chk_read_latency: assert property (
        ind_rd_i && ind_addr_i == IA_EXPECTED ##1 !ind_rd_i |=>
        !ind_rd_valid_o && ind_rdata_o == $past(expected_label_reg, 2))
        else $error("expected setting read mismatch");

endmodule : tpom_monitor

`default_nettype wire

// file: hw/tpom_pkg.sv
package tpom_pkg;

    // Indirect locations
    localparam logic [3:0] IA_PTR_VALUE = 4'h2;
    localparam logic [3:0] IA_LABELS = 4'h3;
    localparam logic [3:0] IA_EXPECTED = 4'h4;
    localparam logic [3:0] IA_PI_FLAGS = 4'h5;
    localparam logic [3:0] IA_PARITY_CNT = 4'h6;
    localparam logic [3:0] IA_REMOTE_CNT = 4'h7;
    localparam logic [3:0] IA_NEG_JUST_CNT = 4'h8;
    localparam logic [3:0] IA_POS_JUST_CNT = 4'h9;

    // Field positions
    localparam int PTR_LSB = 0;
    localparam int SS_LSB = 10;
    localparam int ERDI_LSB = 13;
    localparam int CAPTURED_LSB = 8;
    localparam int ACCEPTED_LSB = 0;
    localparam int EXP_LABEL_LSB = 0;
    localparam int PDI_LSB = 8;
    localparam int PDI_RANGE_BIT = 13;
    localparam int FLAG_ILLJ_BIT = 1;
    localparam int FLAG_CONCAT_BIT = 2;
    localparam int FLAG_DISC_BIT = 3;
    localparam int FLAG_INVALID_NEW_DATA_FLAG_BIT = 4;
    localparam int FLAG_ILLEGAL_OFFSET_FLAG_BIT = 5;
    localparam int FLAG_NDF_BIT = 6;

    // Reset values and writable mask
    localparam logic [15:0] EXPECTED_RST = 16'h0000;
    localparam logic [15:0] EXPECTED_MASK = 16'h3FFF;

    // Frame persistence counts
    localparam int LABEL_FRAMES_LO = 3;
    localparam int LABEL_FRAMES_HI = 5;
    localparam int RDI_FRAMES_LO = 5;
    localparam int RDI_FRAMES_HI = 10;
    localparam int NEW_PTR_FRAMES = 3;
    localparam int JUST_GUARD_FRAMES = 3;

    // Pointer word coding
    localparam logic [9:0] MAX_OFS_STS = 10'd782;
    localparam logic [9:0] MAX_OFS_TU3 = 10'd764;
    localparam logic [9:0] OFS_ALL_ONES = 10'h3FF;
    localparam logic [9:0] I_BIT_MASK = 10'h155;
    localparam logic [9:0] D_BIT_MASK = 10'h2AA;
    localparam logic [3:0] NDF_NORMAL = 4'h6;
    localparam logic [3:0] NDF_ENABLED = 4'h9;
    localparam logic [15:0] AIS_WORD = 16'hFFFF;

    // Labels
    localparam logic [7:0] PDI_BASE = 8'hE0;
    localparam logic [7:0] PDI_RANGE_LO = 8'hE1;
    localparam logic [7:0] LABEL_UNEQ = 8'h00;
    localparam logic [3:0] MAX_BIP_ERRS = 4'h8;

    typedef enum {CNT_PARITY, CNT_REMOTE, CNT_NEG, CNT_POS} tpom_cnt_t;

endpackage : tpom_pkg

// file: test/tpom_line_src.sv
`timescale 1ns/1ps
`default_nettype none

module tpom_line_src (
    // Clock
    input wire logic clk_i,
    // Frame request from the bench
    input wire logic send_i,
    input wire logic [15:0] word_i,
    input wire logic [7:0] c2_i,
    input wire logic [7:0] g1_i,
    input wire logic [3:0] b3_i,
    // Overhead lines toward the monitor
    output logic frame_o,
    output logic [15:0] pointer_word_o,
    output logic [7:0] c2_o,
    output logic [7:0] g1_o,
    output logic [3:0] b3_o
);
    logic [35:0] last_reg = '0;

    // Off the strobe the lines show the inverse of the last frame, so a
    // monitor sampling at the wrong moment reads wrong data, not a copy
    assign frame_o = send_i;
    assign {pointer_word_o, c2_o, g1_o, b3_o} = send_i ?
        {word_i, c2_i, g1_i, b3_i} : ~last_reg;

    always_ff @(posedge clk_i) begin
        if (send_i) begin
            last_reg <= {word_i, c2_i, g1_i, b3_i};
        end
    end
endmodule : tpom_line_src

`default_nettype wire

// file: test/tb_tu3_path_overhead_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module tb_tu3_path_overhead_monitor;
    import tpom_pkg::*;

    logic clk_i, rst_n_i, send, frm, tu3, slave, l5, r10;
    logic ind_rd_i, ind_wr_i, counters_update_i, rdv, lm, uq, pd;
    logic [15:0] word, pw, ind_wdata_i, rdata;
    logic [7:0] c2, g1, c2w, g1w, last_c2, acc_lab;
    logic [3:0] b3, b3w, ind_addr_i, pdx;
    logic [2:0] last_e, erdi;
    logic [15:0] ev [4];
    int par, rei, pos, neg, hpar, hrei, hpos, hneg, c2_run, e_run;
    int fail_count, n_compared;
    localparam logic [15:0] P100 = {NDF_NORMAL, 2'b10, 10'd100};
    localparam logic [15:0] P200 = {NDF_NORMAL, 2'b10, 10'd200};
    localparam logic [15:0] P201 = {NDF_NORMAL, 2'b10, 10'd201};

    tpom_line_src u_src (.clk_i(clk_i), .send_i(send), .word_i(word),
        .c2_i(c2), .g1_i(g1), .b3_i(b3), .frame_o(frm),
        .pointer_word_o(pw), .c2_o(c2w), .g1_o(g1w), .b3_o(b3w));

    tpom_monitor #(.JUST_CNT_W(13), .ERR_CNT_W(16)) u_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .frame_i(frm),
        .pointer_word_i(pw), .c2_i(c2w), .g1_i(g1w), .b3_errors_i(b3w),
        .tu3_mode_i(tu3), .slave_slot_i(slave),
        .label_five_frame_select_i(l5),
        .remote_defect_ten_frame_select_i(r10),
        .ind_rd_i(ind_rd_i), .ind_wr_i(ind_wr_i), .ind_addr_i(ind_addr_i),
        .ind_wdata_i(ind_wdata_i), .counters_update_i(counters_update_i),
        .ind_rdata_o(rdata), .ind_rd_valid_o(rdv),
        .label_mismatch_o(lm), .unequipped_o(uq), .payload_defect_o(pd));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [15:0] s, input logic [15:0] e,
                       input string n);
        n_compared++;
        if (s !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic rd(input logic [3:0] a, input logic [15:0] m,
                      input logic [15:0] e);
        @(posedge clk_i);
        ind_rd_i <= 1'b1;
        ind_addr_i <= a;
        @(posedge clk_i);
        ind_rd_i <= 1'b0;
        #1;
        chk({15'h0, rdv}, 16'h0001, "read valid");
        chk(rdata & m, e, $sformatf("location %0h", a));
    endtask : rd

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        ind_wr_i <= 1'b1;
        ind_addr_i <= a;
        ind_wdata_i <= d;
        @(posedge clk_i);
        ind_wr_i <= 1'b0;
    endtask : wr

    // Sends one frame and advances the reference model by it
    task automatic frame(input logic [15:0] w, input logic u);
        @(posedge clk_i);
        send <= 1'b1;
        word <= w;
        counters_update_i <= u;
        g1 <= {4'($urandom_range(15)), g1[3:0]};
        b3 <= 4'($urandom_range(8));
        @(posedge clk_i);
        send <= 1'b0;
        counters_update_i <= 1'b0;
        #1;
        if (u) begin
            {hpar, hrei, hpos, hneg} = {par, rei, pos, neg};
            {par, rei, pos, neg} = '0;
        end
        par += b3;
        rei += (g1[7:4] > 4'h8) ? 0 : g1[7:4];
        c2_run = (c2 == last_c2) ? c2_run + 1 : 1;
        last_c2 = c2;
        if (c2_run >= (l5 ? 5 : 3)) acc_lab = c2;
        e_run = (g1[3:1] == last_e) ? e_run + 1 : 1;
        last_e = g1[3:1];
        if (e_run >= (r10 ? 10 : 5)) erdi = g1[3:1];
    endtask : frame

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        end_sim();
    end

    initial begin
        {rst_n_i, send, tu3, slave, l5, r10} = '0;
        {ind_rd_i, ind_wr_i, counters_update_i, ind_addr_i} = '0;
        {word, ind_wdata_i, c2, g1, b3, last_c2, acc_lab} = '0;
        {last_e, erdi, par, rei, pos, neg, c2_run, e_run} = '0;
        {fail_count, n_compared} = '0;
        ev = '{16'h2513, 16'h0513, 16'h0313, 16'h2213};
        pdx = 4'b0101;
        void'($urandom(16));
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(4'h4, 16'hFFFF, 16'h0000);
        rd(4'h0, 16'hFFFF, 16'h0000);
        rd(4'hF, 16'hFFFF, 16'h0000);
        chk({15'h0, uq}, 16'h0001, "unequipped");
        wr(4'h4, 16'hFFFF);
        wr(4'h2, 16'h1234);
        rd(4'h4, 16'hFFFF, EXPECTED_MASK);
        rd(4'h2, 16'hFFFF, 16'h0000);
        c2 <= 8'h10 + 8'($urandom_range(15));
        g1 <= 8'h0A;
        for (int i = 0; i < 5; i++) begin
            frame(P100, 1'b0);
            rd(4'h3, 16'hFFFF, {c2, acc_lab});
            if (i == 1) rd(4'h2, 16'h03FF, 16'h0000);
            if (i >= 2) rd(4'h2, 16'hFFFF, {erdi, 3'b010, 10'd100});
            if (i >= 2) rd(4'h5, 16'hFFFF, (i == 2) ? 16'h0008 : 16'h0);
        end
        l5 <= 1'b1;
        r10 <= 1'b1;
        c2 <= 8'h20 + 8'($urandom_range(15));
        g1 <= 8'h06;
        for (int i = 0; i < 10; i++) begin
            frame(P100, 1'b0);
            rd(4'h3, 16'hFFFF, {c2, acc_lab});
            rd(4'h2, 16'hFFFF, {erdi, 3'b010, 10'd100});
        end
        frame({NDF_NORMAL, 2'b10, 10'd783}, 1'b0);
        rd(4'h5, 16'hFFFF, 16'h0020);
        tu3 <= 1'b1;
        frame({NDF_NORMAL, 2'b10, 10'd770}, 1'b0);
        rd(4'h5, 16'hFFFF, 16'h0020);
        tu3 <= 1'b0;
        frame({4'h3, 2'b10, 10'd100}, 1'b0);
        rd(4'h5, 16'hFFFF, 16'h0010);
        slave <= 1'b1;
        frame({4'h3, 2'b10, 10'd100}, 1'b0);
        rd(4'h5, 16'hFFFF, 16'h0000);
        slave <= 1'b0;
        frame(AIS_WORD, 1'b0);
        rd(4'h5, 16'h0020, 16'h0000);
        rd(4'h2, 16'h03FF, 16'd100);
        frame({NDF_ENABLED, 2'b10, 10'd200}, 1'b0);
        rd(4'h5, 16'hFFFF, 16'h0040);
        rd(4'h2, 16'h03FF, 16'd200);
        frame({NDF_ENABLED, 2'b10, OFS_ALL_ONES}, 1'b0);
        rd(4'h5, 16'h0004, 16'h0004);
        frame({NDF_NORMAL, 2'b10, (10'd200 ^ I_BIT_MASK)}, 1'b0);
        rd(4'h5, 16'h0002, 16'h0002);
        rd(4'h2, 16'h03FF, 16'd200);
        repeat (4) frame(P200, 1'b0);
        frame({NDF_NORMAL, 2'b10, (10'd200 ^ I_BIT_MASK)}, 1'b0);
        pos++;
        rd(4'h2, 16'h03FF, 16'd201);
        // Four frames after the increment a decrement is legal again
        repeat (3) frame(P201, 1'b0);
        frame({NDF_NORMAL, 2'b10, (10'd201 ^ D_BIT_MASK)}, 1'b0);
        neg++;
        rd(4'h2, 16'h03FF, 16'd200);
        // The second snapshot must hold only the event of the first one
        for (int k = 0; k < 2; k++) begin
            frame(P200, 1'b1);
            rd(4'h6, 16'hFFFF, 16'(hpar));
            rd(4'h7, 16'hFFFF, 16'(hrei));
            rd(4'h8, 16'hFFFF, 16'(hneg));
            rd(4'h9, 16'hFFFF, 16'(hpos));
        end
        l5 <= 1'b0;
        c2 <= 8'hE3;
        repeat (3) frame(P200, 1'b0);
        for (int k = 0; k < 4; k++) begin
            wr(4'h4, ev[k]);
            repeat (2) @(posedge clk_i);
            #1;
            chk({15'h0, pd}, {15'h0, pdx[k]}, "payload defect");
            chk({15'h0, lm}, {15'h0, ~pdx[k]}, "label mismatch");
            chk({15'h0, uq}, 16'h0000, "unequipped");
        end
        end_sim();
    end
endmodule : tb_tu3_path_overhead_monitor

`default_nettype wire
